// >>> pifb_defs.vh
// register offsets, bit positions and reset values for the peripheral interrupt flag/enable bank
`ifndef PIFB_DEFS_VH
`define PIFB_DEFS_VH

// register indices (byte address is four times the index)
`define PIFB_IDX_FLAGS1    8'h0c
`define PIFB_IDX_FLAGS2    8'h0d
`define PIFB_IDX_MASK1     8'h8c
`define PIFB_IDX_MASK2     8'h8d
`define PIFB_IDX_GATE      8'h8b

// first pair bit positions
`define PIFB_B1_PARPORT    7
`define PIFB_B1_CONV       6
`define PIFB_B1_RX         5
`define PIFB_B1_TX         4
`define PIFB_B1_SYNC       3
`define PIFB_B1_CAPA       2
`define PIFB_B1_PERIOD     1
`define PIFB_B1_WIDE       0

// second pair bit positions
`define PIFB_B2_OSC        7
`define PIFB_B2_CMP        6
`define PIFB_B2_LOWV       5
`define PIFB_B2_COLL       3
`define PIFB_B2_CAPC       1
`define PIFB_B2_CAPB       0
`define PIFB_B2_UNIMP_HI   4
`define PIFB_B2_UNIMP_LO   2

// gate register bit positions
`define PIFB_BG_GLOBAL     7
`define PIFB_BG_PERIPH     6

// implemented-bit masks and reset values
`define PIFB_MASK2_IMPL    8'heb
`define PIFB_GATE_IMPL     8'hc0
`define PIFB_RST_BYTE      8'h00
`define PIFB_RX_TX_BITS    8'h30
`define PIFB_ZERO32        32'h0000_0000

`endif

// >>> pifb_flag_bit.v
// one sticky interrupt flag: hardware set wins over a software write
`timescale 1ns/1ps
module pifb_flag_bit (
   input  wire clk_in,
   input  wire rst_n_in,
   input  wire set_in,
   input  wire wr_in,
   input  wire wdata_in,
   output wire flag_out
);
   reg flag_q;
   reg flag_d;

   // ======================================================
   // next value
   always @* begin
      flag_d = flag_q;
      if (wr_in) begin
         flag_d = wdata_in;
      end
      if (set_in) begin
         flag_d = 1'b1;
      end
   end

   // ======================================================
   // storage
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         flag_q <= 1'b0;
      end else begin
         flag_q <= flag_d;
      end
   end

   assign flag_out = flag_q;
endmodule // pifb_flag_bit

// >>> pifb_irq_bank.v
// peripheral interrupt flag and enable register bank with apb slave
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`include "pifb_defs.vh"

// Operation
// - flags set regardless of enables
// - enable register one, eight bits, reset zero
// - request register one, same order, reset zero
// - parallel port access sets bit seven
// - conversion done sets bit six
// - receive flag read-only, shows buffer full
// - transmit flag read-only, shows buffer empty
// - sync port transfer, or sequence in master mode, sets flag
// - foreign start/stop while idle in master mode sets flag
// - sync port flag sticky until cleared
// - capture/compare units set on capture or match, except a unit in pwm mode
// - period timer match sets bit one
// - wide timer overflow sets bit zero
// - enable register two layout, reset zero
// - request register two same positions
// - bits four and two read zero
// - oscillator failure sets bit seven
// - comparator change and low supply set flags
// - collision flag only in master mode
// - peripheral gate required for the core request, not periph_irq_out
// - global enable blocks the core request only, not periph_irq_out
module pifb_irq_bank (
   input  wire        ref_clk_in,
   input  wire        reset_n_in,
   // apb slave
   input  wire        psel_in,
   input  wire        penable_in,
   input  wire        pwrite_in,
   input  wire [11:0] paddr_in,
   input  wire [31:0] pwdata_in,
   input  wire [3:0]  pstrb_in,
   output wire        pready_out,
   output reg  [31:0] prdata_out,
   output wire        pslverr_out,
   // peripheral event pulses and status levels
   input  wire        parport_access_in,
   input  wire        conversion_done_in,
   input  wire        serial_rx_full_in,
   input  wire        serial_tx_empty_in,
   input  wire        sync_xfer_done_in,
   input  wire        sync_master_mode_in,
   input  wire        sync_seq_done_in,
   input  wire        sync_idle_in,
   input  wire        sync_bus_start_stop_in,
   input  wire        sync_collision_in,
   input  wire [2:0]  capcmp_mode_pwm_in,
   input  wire [2:0]  capcmp_event_in,
   input  wire        period_match_in,
   input  wire        wide_timer_ovf_in,
   input  wire        osc_fail_in,
   input  wire        comparator_change_in,
   input  wire        low_supply_in,
   // request to core
   output reg         periph_irq_out,
   output reg         core_irq_out
);
   // ======================================================
   // reset release through two flip-flops
   reg rst_meta_q;
   reg rst_sync_q;
   always @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end
   wire rst_n = rst_sync_q;

   // ======================================================
   // apb decode
   function sel_idx;
      input [11:0] addr;
      input [7:0]  idx;
      begin
         sel_idx = (addr[11:2] == {2'b00, idx}) && (addr[1:0] == 2'b00);
      end
   endfunction

   wire access    = psel_in & penable_in;
   wire wr_lane0  = access & pwrite_in & pstrb_in[0];
   wire hit_f1    = sel_idx(paddr_in, `PIFB_IDX_FLAGS1);
   wire hit_f2    = sel_idx(paddr_in, `PIFB_IDX_FLAGS2);
   wire hit_m1    = sel_idx(paddr_in, `PIFB_IDX_MASK1);
   wire hit_m2    = sel_idx(paddr_in, `PIFB_IDX_MASK2);
   wire hit_gate  = sel_idx(paddr_in, `PIFB_IDX_GATE);
   wire hit_any   = hit_f1 | hit_f2 | hit_m1 | hit_m2 | hit_gate;
   wire wr_f1     = wr_lane0 & hit_f1;
   wire wr_f2     = wr_lane0 & hit_f2;

   // zero wait states; unmapped address answers with an error
   assign pready_out  = 1'b1;
   assign pslverr_out = access & ~hit_any;

   // ======================================================
   // enable registers and core gate bits
   reg [7:0] mask1_q;
   reg [7:0] mask2_q;
   reg [7:0] gate_q;
   always @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         mask1_q <= `PIFB_RST_BYTE;
         mask2_q <= `PIFB_RST_BYTE;
         gate_q  <= `PIFB_RST_BYTE;
      end else if (wr_lane0) begin
         if (hit_m1) begin
            mask1_q <= pwdata_in[7:0];
         end
         if (hit_m2) begin
            mask2_q <= pwdata_in[7:0] & `PIFB_MASK2_IMPL;
         end
         if (hit_gate) begin
            gate_q <= pwdata_in[7:0] & `PIFB_GATE_IMPL;
         end
      end
   end

   // ======================================================
   // set conditions for each sticky flag, independent of any enable
   wire [2:0] capcmp_set = capcmp_event_in & ~capcmp_mode_pwm_in;
   wire sync_set = sync_xfer_done_in
                 | (sync_master_mode_in & sync_seq_done_in)
                 | (sync_master_mode_in & sync_idle_in & sync_bus_start_stop_in);
   wire coll_set = sync_master_mode_in & sync_collision_in;

   wire [7:0] set1;
   assign set1[`PIFB_B1_PARPORT] = parport_access_in;
   assign set1[`PIFB_B1_CONV]    = conversion_done_in;
   assign set1[`PIFB_B1_RX]      = 1'b0;
   assign set1[`PIFB_B1_TX]      = 1'b0;
   assign set1[`PIFB_B1_SYNC]    = sync_set;
   assign set1[`PIFB_B1_CAPA]    = capcmp_set[0];
   assign set1[`PIFB_B1_PERIOD]  = period_match_in;
   assign set1[`PIFB_B1_WIDE]    = wide_timer_ovf_in;

   wire [7:0] set2;
   assign set2[`PIFB_B2_OSC]  = osc_fail_in;
   assign set2[`PIFB_B2_CMP]  = comparator_change_in;
   assign set2[`PIFB_B2_LOWV] = low_supply_in;
   assign set2[`PIFB_B2_UNIMP_HI] = 1'b0;
   assign set2[`PIFB_B2_COLL] = coll_set;
   assign set2[`PIFB_B2_UNIMP_LO] = 1'b0;
   assign set2[`PIFB_B2_CAPC] = capcmp_set[2];
   assign set2[`PIFB_B2_CAPB] = capcmp_set[1];

   // ======================================================
   // sticky flag cells, one per read/write flag; no storage for live or unimplemented bits
   wire parport_access_irq_flag;
   wire conversion_done_irq_flag;
   wire sync_port_irq_flag;
   wire capcmp_a_irq_flag;
   wire period_match_irq_flag;
   wire wide_timer_ovf_irq_flag;
   wire osc_fail_irq_flag;
   wire comparator_change_irq_flag;
   wire low_supply_irq_flag;
   wire collision_irq_flag;
   wire capcmp_c_irq_flag;
   wire capcmp_b_irq_flag;

   // parallel port access flag
   pifb_flag_bit u_parport_flag (
      .clk_in   (ref_clk_in),
      .rst_n_in (rst_n),
      .set_in   (set1[`PIFB_B1_PARPORT]),
      .wr_in    (wr_f1),
      .wdata_in (pwdata_in[`PIFB_B1_PARPORT]),
      .flag_out (parport_access_irq_flag)
   );
   // conversion done flag
   pifb_flag_bit u_conv_flag (
      .clk_in   (ref_clk_in),
      .rst_n_in (rst_n),
      .set_in   (set1[`PIFB_B1_CONV]),
      .wr_in    (wr_f1),
      .wdata_in (pwdata_in[`PIFB_B1_CONV]),
      .flag_out (conversion_done_irq_flag)
   );
   // synchronous serial port flag
   pifb_flag_bit u_sync_flag (
      .clk_in   (ref_clk_in),
      .rst_n_in (rst_n),
      .set_in   (set1[`PIFB_B1_SYNC]),
      .wr_in    (wr_f1),
      .wdata_in (pwdata_in[`PIFB_B1_SYNC]),
      .flag_out (sync_port_irq_flag)
   );
   // capture/compare unit a flag
   pifb_flag_bit u_capa_flag (
      .clk_in   (ref_clk_in),
      .rst_n_in (rst_n),
      .set_in   (set1[`PIFB_B1_CAPA]),
      .wr_in    (wr_f1),
      .wdata_in (pwdata_in[`PIFB_B1_CAPA]),
      .flag_out (capcmp_a_irq_flag)
   );
   // period timer match flag
   pifb_flag_bit u_period_flag (
      .clk_in   (ref_clk_in),
      .rst_n_in (rst_n),
      .set_in   (set1[`PIFB_B1_PERIOD]),
      .wr_in    (wr_f1),
      .wdata_in (pwdata_in[`PIFB_B1_PERIOD]),
      .flag_out (period_match_irq_flag)
   );
   // wide timer overflow flag
   pifb_flag_bit u_wide_flag (
      .clk_in   (ref_clk_in),
      .rst_n_in (rst_n),
      .set_in   (set1[`PIFB_B1_WIDE]),
      .wr_in    (wr_f1),
      .wdata_in (pwdata_in[`PIFB_B1_WIDE]),
      .flag_out (wide_timer_ovf_irq_flag)
   );
   // oscillator failure flag
   pifb_flag_bit u_osc_flag (
      .clk_in   (ref_clk_in),
      .rst_n_in (rst_n),
      .set_in   (set2[`PIFB_B2_OSC]),
      .wr_in    (wr_f2),
      .wdata_in (pwdata_in[`PIFB_B2_OSC]),
      .flag_out (osc_fail_irq_flag)
   );
   // comparator change flag
   pifb_flag_bit u_cmp_flag (
      .clk_in   (ref_clk_in),
      .rst_n_in (rst_n),
      .set_in   (set2[`PIFB_B2_CMP]),
      .wr_in    (wr_f2),
      .wdata_in (pwdata_in[`PIFB_B2_CMP]),
      .flag_out (comparator_change_irq_flag)
   );
   // low supply flag
   pifb_flag_bit u_lowv_flag (
      .clk_in   (ref_clk_in),
      .rst_n_in (rst_n),
      .set_in   (set2[`PIFB_B2_LOWV]),
      .wr_in    (wr_f2),
      .wdata_in (pwdata_in[`PIFB_B2_LOWV]),
      .flag_out (low_supply_irq_flag)
   );
   // bus collision flag
   pifb_flag_bit u_coll_flag (
      .clk_in   (ref_clk_in),
      .rst_n_in (rst_n),
      .set_in   (set2[`PIFB_B2_COLL]),
      .wr_in    (wr_f2),
      .wdata_in (pwdata_in[`PIFB_B2_COLL]),
      .flag_out (collision_irq_flag)
   );
   // capture/compare unit c flag
   pifb_flag_bit u_capc_flag (
      .clk_in   (ref_clk_in),
      .rst_n_in (rst_n),
      .set_in   (set2[`PIFB_B2_CAPC]),
      .wr_in    (wr_f2),
      .wdata_in (pwdata_in[`PIFB_B2_CAPC]),
      .flag_out (capcmp_c_irq_flag)
   );
   // capture/compare unit b flag
   pifb_flag_bit u_capb_flag (
      .clk_in   (ref_clk_in),
      .rst_n_in (rst_n),
      .set_in   (set2[`PIFB_B2_CAPB]),
      .wr_in    (wr_f2),
      .wdata_in (pwdata_in[`PIFB_B2_CAPB]),
      .flag_out (capcmp_b_irq_flag)
   );

   // ======================================================
   // sticky images in register bit order; live and unimplemented bits hold zero
   wire [7:0] sticky1;
   wire [7:0] sticky2;
   assign sticky1[`PIFB_B1_PARPORT]  = parport_access_irq_flag;
   assign sticky1[`PIFB_B1_CONV]     = conversion_done_irq_flag;
   assign sticky1[`PIFB_B1_RX]       = 1'b0;
   assign sticky1[`PIFB_B1_TX]       = 1'b0;
   assign sticky1[`PIFB_B1_SYNC]     = sync_port_irq_flag;
   assign sticky1[`PIFB_B1_CAPA]     = capcmp_a_irq_flag;
   assign sticky1[`PIFB_B1_PERIOD]   = period_match_irq_flag;
   assign sticky1[`PIFB_B1_WIDE]     = wide_timer_ovf_irq_flag;
   assign sticky2[`PIFB_B2_OSC]      = osc_fail_irq_flag;
   assign sticky2[`PIFB_B2_CMP]      = comparator_change_irq_flag;
   assign sticky2[`PIFB_B2_LOWV]     = low_supply_irq_flag;
   assign sticky2[`PIFB_B2_UNIMP_HI] = 1'b0;
   assign sticky2[`PIFB_B2_COLL]     = collision_irq_flag;
   assign sticky2[`PIFB_B2_UNIMP_LO] = 1'b0;
   assign sticky2[`PIFB_B2_CAPC]     = capcmp_c_irq_flag;
   assign sticky2[`PIFB_B2_CAPB]     = capcmp_b_irq_flag;

   // ======================================================
   // visible request registers
   wire [7:0] flags1;
   assign flags1 = (sticky1 & ~`PIFB_RX_TX_BITS)
                 | {2'b00, serial_rx_full_in, serial_tx_empty_in, 4'h0};
   wire [7:0] flags2 = sticky2 & `PIFB_MASK2_IMPL;

   // ======================================================
   // request outputs
   wire any_pending = (|(flags1 & mask1_q)) | (|(flags2 & mask2_q));
   always @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         periph_irq_out <= 1'b0;
         core_irq_out   <= 1'b0;
      end else begin
         periph_irq_out <= any_pending;
         core_irq_out   <= any_pending & gate_q[`PIFB_BG_PERIPH]
                         & gate_q[`PIFB_BG_GLOBAL];
      end
   end

   // ======================================================
   // read data, registered at setup so it is stable in the access phase
   always @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         prdata_out <= `PIFB_ZERO32;
      end else if (psel_in & ~penable_in & ~pwrite_in) begin
         prdata_out <= `PIFB_ZERO32;
         if (hit_f1) begin
            prdata_out[7:0] <= flags1;
         end
         if (hit_f2) begin
            prdata_out[7:0] <= flags2;
         end
         if (hit_m1) begin
            prdata_out[7:0] <= mask1_q;
         end
         if (hit_m2) begin
            prdata_out[7:0] <= mask2_q;
         end
         if (hit_gate) begin
            prdata_out[7:0] <= gate_q;
         end
      end
   end
endmodule // pifb_irq_bank

// >>> pifb_irq_bank_monitor.sv
// assertion checker for the interrupt bank bus and request outputs
`timescale 1ns/1ps
`include "pifb_defs.vh"
module pifb_irq_bank_monitor (
   input wire        ref_clk_in,
   input wire        reset_n_in,
   input wire        psel_in,
   input wire        penable_in,
   input wire        pwrite_in,
   input wire [11:0] paddr_in,
   input wire        pready_out,
   input wire [31:0] prdata_out,
   input wire        pslverr_out,
   input wire        serial_rx_full_in,
   input wire        serial_tx_empty_in,
   input wire        periph_irq_out,
   input wire        core_irq_out
);
   // =========================================
   // helpers
   localparam [11:0] F1 = {2'b00, `PIFB_IDX_FLAGS1, 2'b00};
   localparam [11:0] F2 = {2'b00, `PIFB_IDX_FLAGS2, 2'b00};
   localparam [11:0] M1 = {2'b00, `PIFB_IDX_MASK1, 2'b00};
   localparam [11:0] M2 = {2'b00, `PIFB_IDX_MASK2, 2'b00};
   localparam [11:0] GT = {2'b00, `PIFB_IDX_GATE, 2'b00};
   wire acc = psel_in && penable_in;
   wire wr  = acc && pwrite_in;
   wire rdf = acc && !pwrite_in;
   wire map = (paddr_in == F1) || (paddr_in == F2) || (paddr_in == M1) || (paddr_in == M2) || (paddr_in == GT);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!reset_n_in);
   // bus answers
   a_err_on_unmapped: assert property (acc |-> pslverr_out == !map) else $error("error response wrong");
   a_unmapped_reads_zero: assert property (rdf && !map |-> prdata_out == 32'h0) else $error("unmapped data");
   a_upper_bits_zero: assert property (rdf |-> prdata_out[31:8] == 24'h0) else $error("upper read bits set");
   a_live_rx_tx: assert property (rdf && paddr_in == F1 |->
      prdata_out[5:4] == {$past(serial_rx_full_in), $past(serial_tx_empty_in)}) else $error("rx tx view");
   a_unimpl_read_zero: assert property (rdf && (paddr_in == F2 || paddr_in == M2) |->
      prdata_out[4] == 1'b0 && prdata_out[2] == 1'b0) else $error("unimplemented bit set");
   a_gate_rsvd_zero: assert property (rdf && paddr_in == GT |-> prdata_out[5:0] == 6'h0) else $error("gate bits");
   // request outputs
   a_core_needs_periph: assert property (core_irq_out |-> periph_irq_out || $past(periph_irq_out))
      else $error("core request alone");
   a_irq_drop_cause: assert property ($fell(periph_irq_out) |-> $past(wr) || $past(wr, 2)
      || $past(!serial_rx_full_in) || $past(!serial_tx_empty_in)) else $error("request dropped");
   c_core: cover property (core_irq_out);
   c_err: cover property (pslverr_out);
   c_drop: cover property ($fell(periph_irq_out));
endmodule // pifb_irq_bank_monitor

bind pifb_irq_bank pifb_irq_bank_monitor u_pifb_irq_bank_monitor (.ref_clk_in(ref_clk_in),
   .reset_n_in(reset_n_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
   .paddr_in(paddr_in), .pready_out(pready_out), .prdata_out(prdata_out), .pslverr_out(pslverr_out),
   .serial_rx_full_in(serial_rx_full_in), .serial_tx_empty_in(serial_tx_empty_in),
   .periph_irq_out(periph_irq_out), .core_irq_out(core_irq_out));

// >>> pifb_irq_bank_test.sv
// self-checking bench for the peripheral interrupt bank
`timescale 1ns/1ps
`include "pifb_defs.vh"
module pifb_irq_bank_test;
   // =========================================
   // stimulus and checks
   localparam [11:0] F1 = {2'b00, `PIFB_IDX_FLAGS1, 2'b00};
   localparam [11:0] F2 = {2'b00, `PIFB_IDX_FLAGS2, 2'b00};
   localparam [11:0] M1 = {2'b00, `PIFB_IDX_MASK1, 2'b00};
   localparam [11:0] M2 = {2'b00, `PIFB_IDX_MASK2, 2'b00};
   localparam [11:0] GT = {2'b00, `PIFB_IDX_GATE, 2'b00};
   logic        clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, rx = 0, tx = 0, mst = 0, idl = 0, err_q;
   logic [11:0] paddr = 0, ra;
   logic [31:0] pwdata = 0, rd;
   logic [2:0]  pwm = 0;
   logic [13:0] req = 0;
   wire  [13:0] ev;
   wire  [31:0] prdata;
   wire         prdy, pslv, pirq, cirq;
   int          error_cnt = 0, comparisons = 0, i;
   int          bitpos [14] = '{0, 1, 2, 3, 6, 7, 0, 1, 3, 5, 6, 7, 3, 3};
   pifb_periph_model u_pifb_periph_model (.clk_in(clk), .req_in(req), .ev_out(ev));
   pifb_irq_bank u_pifb_irq_bank (.ref_clk_in(clk), .reset_n_in(rst_n), .psel_in(psel), .penable_in(pen),
      .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(4'hf), .pready_out(prdy),
      .prdata_out(prdata), .pslverr_out(pslv), .parport_access_in(ev[5]), .conversion_done_in(ev[4]),
      .serial_rx_full_in(rx), .serial_tx_empty_in(tx), .sync_xfer_done_in(ev[3]), .sync_master_mode_in(mst),
      .sync_seq_done_in(ev[12]), .sync_idle_in(idl), .sync_bus_start_stop_in(ev[13]),
      .sync_collision_in(ev[8]), .capcmp_mode_pwm_in(pwm), .capcmp_event_in({ev[7], ev[6], ev[2]}),
      .period_match_in(ev[1]), .wide_timer_ovf_in(ev[0]), .osc_fail_in(ev[11]),
      .comparator_change_in(ev[10]), .low_supply_in(ev[9]), .periph_irq_out(pirq), .core_irq_out(cirq));
   // clock
   initial begin
      forever #12.5 clk = ~clk;
   end
   // one bus transfer; events requested here pulse during its access phase
   task xfer(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [13:0] m);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      req <= m;
      @(posedge clk);
      pen <= 1'b1;
      req <= 14'h0;
      do @(posedge clk); while (prdy !== 1'b1);
      rd = prdata;
      err_q = pslv;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task tally_and_finish;
      $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // watchdog well beyond the few hundred cycles the tests need
   initial begin
      #500000;
      error_cnt++;
      tally_and_finish;
   end
   // main sequence
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      for (i = 0; i < 5; i++) begin
         ra = (i == 0) ? F1 : (i == 1) ? F2 : (i == 2) ? M1 : (i == 3) ? M2 : GT;
         xfer(1'b0, ra, 8'h00, 14'h0);
         chk("reset value", 32'h0, rd);
      end
      xfer(1'b0, GT, 8'h00, 14'h1);
      xfer(1'b0, F1, 8'h00, 14'h0);
      chk("flag without enable", 32'h1, rd);
      chk("masked request", 32'h0, {31'h0, pirq});
      xfer(1'b1, F1, 8'h00, 14'h0);
      xfer(1'b1, M1, 8'hff, 14'h0);
      xfer(1'b0, M1, 8'h00, 14'h0);
      chk("mask one", 32'hff, rd);
      xfer(1'b1, M2, 8'hff, 14'h0);
      xfer(1'b0, M2, 8'h00, 14'h0);
      chk("mask two", 32'heb, rd);
      mst <= 1'b1;
      idl <= 1'b1;
      // every event source, read back, then cleared by software
      for (i = 0; i < 14; i++) begin
         ra = (i < 6 || i > 11) ? F1 : F2;
         xfer(1'b0, GT, 8'h00, 14'(1 << i));
         xfer(1'b0, ra, 8'h00, 14'h0);
         chk("event flag", 32'(1 << bitpos[i]), rd);
         chk("request raised", 32'h1, {31'h0, pirq});
         xfer(1'b1, ra, 8'h00, 14'h0);
         repeat (2) @(posedge clk);
         chk("request cleared", 32'h0, {31'h0, pirq});
      end
      xfer(1'b0, GT, 8'h00, 14'h10);
      xfer(1'b1, F1, 8'h00, 14'h10);
      xfer(1'b0, F1, 8'h00, 14'h0);
      chk("set beats clear", 32'h40, rd);
      xfer(1'b1, F1, 8'h00, 14'h0);
      pwm <= 3'h7;
      mst <= 1'b0;
      xfer(1'b0, GT, 8'h00, 14'h1c4);
      xfer(1'b0, F1, 8'h00, 14'h0);
      chk("pwm unit one", 32'h0, rd);
      xfer(1'b0, F2, 8'h00, 14'h0);
      chk("pwm and collision", 32'h0, rd);
      rx <= 1'b1;
      tx <= 1'b1;
      xfer(1'b1, F1, 8'h00, 14'h0);
      xfer(1'b0, F1, 8'h00, 14'h0);
      chk("rx tx live", 32'h30, rd);
      xfer(1'b1, GT, 8'hc0, 14'h0);
      repeat (2) @(posedge clk);
      chk("core request", 32'h1, {31'h0, cirq});
      xfer(1'b1, GT, 8'h40, 14'h0);
      repeat (2) @(posedge clk);
      chk("global block", 32'h0, {31'h0, cirq});
      rx <= 1'b0;
      tx <= 1'b0;
      repeat (2) @(posedge clk);
      chk("request idle", 32'h0, {31'h0, pirq});
      xfer(1'b1, 12'h100, 8'hff, 14'h0);
      chk("error response", 32'h1, {31'h0, err_q});
      xfer(1'b0, 12'h100, 8'h00, 14'h0);
      chk("unmapped read", 32'h0, rd);
      tally_and_finish;
   end
endmodule // pifb_irq_bank_test

// >>> pifb_periph_model.sv
// peripheral event source model for the interrupt bank
`timescale 1ns/1ps
module pifb_periph_model (
   input  wire        clk_in,
   input  wire [13:0] req_in,
   output reg  [13:0] ev_out
);
   // =========================================
   // event pulses
   // a requested event shows for exactly one cycle after the edge
   always @(posedge clk_in) begin
      ev_out <= req_in;
   end
endmodule // pifb_periph_model
